// >>> rtl/flash_reset_pkg.sv
// Purpose: Constants and types for the flash reset sequencer
// Assumes: pclk at 10 MHz
// Notes:   Offsets are byte addresses on a 32-bit APB
package flash_reset_pkg;

  localparam int unsigned CLK_NS             = 100;
  localparam int unsigned SUPPLY_SETTLE_US   = 300;
  localparam int unsigned RESTART_SEL_US     = 30;
  localparam int unsigned RESTART_PULSE_NS   = 200;
  localparam int unsigned EXT_TICK_US        = 25;
  localparam int unsigned SLEEP_WAKE_US      = 300;
  localparam int unsigned SUPPLY_SETTLE_CYC  = (SUPPLY_SETTLE_US * 1000) / CLK_NS;
  localparam int unsigned RESTART_SEL_CYC    = (RESTART_SEL_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned RESTART_PULSE_CYC  = (RESTART_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned EXT_TICK_CYC       = (EXT_TICK_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned SLEEP_WAKE_CYC     = (SLEEP_WAKE_US * 1000) / CLK_NS / 2;

  localparam logic [7:0]  ADDR_EXTENSION     = 8'h00;
  localparam logic [7:0]  ADDR_STATUS        = 8'h04;
  localparam logic [7:0]  ADDR_CONTROL       = 8'h08;
  localparam logic [7:0]  ADDR_BUS_CONFIG    = 8'h0c;
  localparam logic [15:0] EXTENSION_RESET    = 16'hffff;
  localparam logic [15:0] BUS_CONFIG_RESET   = 16'h0000;
  localparam int unsigned CTRL_SLEEP_BIT     = 0;
  localparam int unsigned CTRL_EA_START_BIT  = 1;
  localparam int unsigned CTRL_OVERLAY_BIT   = 2;

  typedef enum logic [2:0] {
    ST_COLD,
    ST_EXTEND,
    ST_WARM,
    ST_HW_HOLD,
    ST_STANDBY,
    ST_SLEEP,
    ST_WAKE
  } seq_state_t;

  typedef struct packed {
    logic       ext_programmed;
    logic       ext_fail;
    logic       por_done;
    logic       algo_busy;
    logic       overlay;
    logic [2:0] state;
  } status_t;

endpackage

// >>> rtl/flash_reset_sequencer.sv
// Purpose: Cold and warm reset sequencing of a serial NOR flash, with
//          open-drain system reset output and deep-sleep wake by reset.
// Assumes: presetn models supply reaching its minimum; inputs synchronous.
// Notes:   Extension count and bus configuration cells survive presetn
// Operation
// - Ignore restart and select during cold reset
// - Block commands, outputs while reset output low
// - After power-on: hold if restart low
// - Incomplete power-on: later reset runs cold
// - Hold reset output low, release then Standby
// - Extension count 16-bit, all-ones adds nothing
// - Extend by count plus one ticks
// - Extension count programmable only once
// - Hardware reset aborts, clears, tristates
// - Data lines tristated while restart low
// - Select ignored for whole warm reset
// - No command processing while restart low
// - Load bus configuration on reset completion (code loads it in warm, hold and wake, not on cold reset into Standby)
// - Warm reset after completed power-on
// - After warm reset wait for restart high
// - Restart pulse wakes from deep sleep
// - Wake to Standby within 300 us
`timescale 1ns/1ps
module flash_reset_sequencer
#(
  parameter int unsigned SETTLE_CYC = flash_reset_pkg::SUPPLY_SETTLE_CYC,
  parameter int unsigned WARM_CYC   = flash_reset_pkg::RESTART_SEL_CYC,
  parameter int unsigned TICK_CYC   = flash_reset_pkg::EXT_TICK_CYC,
  parameter int unsigned WAKE_CYC   = flash_reset_pkg::SLEEP_WAKE_CYC
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // APB slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  // Flash pins
  input  wire logic             restart_n,
  input  wire logic             select_n,
  output logic                  system_restart_out_n_o,
  output logic                  system_restart_out_n_oe,
  output logic                  data_oe,
  // Core side
  output logic                  select_accept,
  output logic                  cmd_enable,
  output logic [15:0]           bus_config
);
  import flash_reset_pkg::*;

  seq_state_t  state_reg;
  logic [31:0] cnt_reg;
  logic [15:0] ext_left_reg;
  logic [15:0] ext_reg           = EXTENSION_RESET;
  logic        ext_prog_reg      = 1'b0;
  logic        ext_fail_reg;
  logic        por_done_reg;
  logic [15:0] nv_bus_config_reg = BUS_CONFIG_RESET;
  logic        algo_busy_reg;
  logic        overlay_reg;
  logic        sleep_req;
  logic        wr_en;
  status_t     status;

  function automatic logic addr_known(input logic [7:0] a);
    return a == ADDR_EXTENSION || a == ADDR_STATUS || a == ADDR_CONTROL || a == ADDR_BUS_CONFIG;
  endfunction

  assign wr_en     = psel && penable && pwrite && addr_known(paddr);
  assign sleep_req = wr_en && paddr == ADDR_CONTROL && pwdata[CTRL_SLEEP_BIT];

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg    <= ST_COLD;
      cnt_reg      <= 32'h0000_0000;
      ext_left_reg <= 16'h0000;
      por_done_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_COLD: begin
          // Select is not looked at here; restart is sampled only once the settle count ends
          if (cnt_reg >= 32'(SETTLE_CYC - 1)) begin
            cnt_reg <= 32'h0000_0000;
            if (ext_reg == EXTENSION_RESET) begin
              por_done_reg <= 1'b1;
              state_reg    <= restart_n ? ST_STANDBY : ST_HW_HOLD;
            end else begin
              ext_left_reg <= ext_reg;
              state_reg    <= ST_EXTEND;
            end
          end else begin
            cnt_reg <= cnt_reg + 32'h0000_0001;
          end
        end
        ST_EXTEND: begin
          // Count plus one ticks; the final tick lands at ext_left zero
          if (cnt_reg >= 32'(TICK_CYC - 1)) begin
            cnt_reg <= 32'h0000_0000;
            if (ext_left_reg == 16'h0000) begin
              por_done_reg <= 1'b1;
              state_reg    <= restart_n ? ST_STANDBY : ST_HW_HOLD;
            end else begin
              ext_left_reg <= ext_left_reg - 16'h0001;
            end
          end else begin
            cnt_reg <= cnt_reg + 32'h0000_0001;
          end
        end
        ST_WARM: begin
          // Select ignored until the warm algorithm is through
          if (cnt_reg >= 32'(WARM_CYC - 1)) begin
            cnt_reg   <= 32'h0000_0000;
            state_reg <= restart_n ? ST_STANDBY : ST_HW_HOLD;
          end else begin
            cnt_reg <= cnt_reg + 32'h0000_0001;
          end
        end
        ST_HW_HOLD: begin
          if (restart_n) begin
            state_reg <= ST_STANDBY;
          end
        end
        ST_STANDBY: begin
          if (!restart_n) begin
            cnt_reg   <= 32'h0000_0000;
            // A cold reset that never finished is rerun
            state_reg <= por_done_reg ? ST_WARM : ST_COLD;
          end else if (sleep_req) begin
            state_reg <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (!restart_n) begin
            cnt_reg   <= 32'h0000_0000;
            state_reg <= ST_WAKE;
          end
        end
        ST_WAKE: begin
          // Wake is bounded well inside the 300 us limit
          if (cnt_reg >= 32'(WAKE_CYC - 1) && restart_n) begin
            cnt_reg   <= 32'h0000_0000;
            state_reg <= ST_STANDBY;
          end else if (cnt_reg < 32'(WAKE_CYC - 1)) begin
            cnt_reg <= cnt_reg + 32'h0000_0001;
          end
        end
        default: begin
          state_reg <= ST_COLD;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin and core controls
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      system_restart_out_n_o  <= 1'b0;
      system_restart_out_n_oe <= 1'b1;
      data_oe                 <= 1'b0;
      select_accept           <= 1'b0;
      cmd_enable              <= 1'b0;
    end else begin
      system_restart_out_n_o  <= 1'b0;
      // Low only while cold reset or its extension runs
      system_restart_out_n_oe <= (state_reg == ST_COLD || state_reg == ST_EXTEND);
      // Data lines only in Standby with restart high
      data_oe                 <= state_reg == ST_STANDBY && restart_n && !select_n;
      select_accept           <= state_reg == ST_STANDBY && restart_n;
      cmd_enable              <= state_reg == ST_STANDBY && restart_n;
    end
  end

  // ----------------------------------------------------------------
  // Algorithm controller state and bus configuration
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      algo_busy_reg <= 1'b0;
      overlay_reg   <= 1'b0;
      bus_config    <= BUS_CONFIG_RESET;
    end else if (state_reg != ST_STANDBY || !restart_n) begin
      // Abort running work, leave overlay, idle the controller
      algo_busy_reg <= 1'b0;
      overlay_reg   <= 1'b0;
      if (state_reg == ST_WARM || state_reg == ST_HW_HOLD || state_reg == ST_WAKE) begin
        bus_config <= nv_bus_config_reg;
      end
    end else if (wr_en && paddr == ADDR_CONTROL) begin
      algo_busy_reg <= pwdata[CTRL_EA_START_BIT];
      overlay_reg   <= pwdata[CTRL_OVERLAY_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Nonvolatile registers
  // ----------------------------------------------------------------
  // No reset: these cells keep their contents over a supply cycle, so a
  // programmed extension is seen by the next cold reset
  always_ff @(posedge pclk) begin
    if (wr_en && cmd_enable) begin
      if (paddr == ADDR_EXTENSION && !ext_prog_reg) begin
        ext_reg      <= pwdata[15:0];
        ext_prog_reg <= 1'b1;
      end
      if (paddr == ADDR_BUS_CONFIG) begin
        nv_bus_config_reg <= pwdata[15:0];
      end
    end
  end

  // Failure flag is status: cleared by presetn and by warm reset (not by wake from sleep), set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_fail_reg <= 1'b0;
    end else if (wr_en && cmd_enable && paddr == ADDR_EXTENSION && ext_prog_reg) begin
      ext_fail_reg <= 1'b1;
    end else if (state_reg == ST_WARM) begin
      ext_fail_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // APB read path
  // ----------------------------------------------------------------
  always_comb begin
    status.ext_programmed = ext_prog_reg;
    status.ext_fail       = ext_fail_reg;
    status.por_done       = por_done_reg;
    status.algo_busy      = algo_busy_reg;
    status.overlay        = overlay_reg;
    status.state          = state_reg;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addr_known(paddr);
      if (psel && !penable && !pwrite) begin
        case (paddr)
          ADDR_EXTENSION:  prdata <= {16'h0000, ext_reg};
          ADDR_STATUS:     prdata <= {24'h000000, status};
          ADDR_BUS_CONFIG: prdata <= {16'h0000, nv_bus_config_reg};
          default:         prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_cold_done;
    state_reg == ST_COLD && cnt_reg == 32'(SETTLE_CYC - 1) && ext_reg == EXTENSION_RESET;
  endsequence

  a_cold_ignores_inputs: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == ST_COLD |=> !select_accept)
    else $error("select accepted during cold reset");

  a_reset_blocks_cmds: assert property (@(posedge pclk) disable iff (!presetn)
    system_restart_out_n_oe |-> !cmd_enable && !data_oe)
    else $error("command or output while reset out low");

  a_cold_hold_low: assert property (@(posedge pclk) disable iff (!presetn)
    s_cold_done ##0 !restart_n |=> state_reg == ST_HW_HOLD)
    else $error("no hold after cold reset with restart low");

  a_release_standby: assert property (@(posedge pclk) disable iff (!presetn)
    s_cold_done ##0 restart_n |=> state_reg == ST_STANDBY ##1 !system_restart_out_n_oe)
    else $error("reset output not released");

  a_ext_once: assert property (@(posedge pclk) disable iff (!presetn)
    ext_prog_reg |=> $stable(ext_reg))
    else $error("extension count changed twice");

  a_data_tristate: assert property (@(posedge pclk) disable iff (!presetn)
    !restart_n |=> !data_oe)
    else $error("data driven while restart low");

  a_warm_route: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == ST_STANDBY && !restart_n && por_done_reg |=> state_reg == ST_WARM)
    else $error("warm reset not started");

  a_sleep_wake: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == ST_SLEEP && !restart_n |=> state_reg == ST_WAKE)
    else $error("restart did not wake from sleep");

  sequence s_tick_last;
    state_reg == ST_EXTEND && cnt_reg >= 32'(TICK_CYC - 1) && ext_left_reg == 16'h0000;
  endsequence

  sequence s_wake_ready;
    state_reg == ST_WAKE && cnt_reg >= 32'(WAKE_CYC - 1) && restart_n;
  endsequence

  a_extend_holds_low: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == ST_EXTEND |=> system_restart_out_n_oe)
    else $error("reset output released during extension");

  a_extend_release: assert property (@(posedge pclk) disable iff (!presetn)
    s_tick_last |=> state_reg != ST_EXTEND && por_done_reg)
    else $error("extension did not end after its last tick");

  a_ext_fail_flag: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && cmd_enable && paddr == ADDR_EXTENSION && ext_prog_reg |=> ext_fail_reg)
    else $error("second program attempt not flagged");

  a_abort_clears: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg != ST_STANDBY |=> !algo_busy_reg && !overlay_reg)
    else $error("algorithm or overlay kept through reset");

  a_warm_no_select: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == ST_WARM |=> !select_accept)
    else $error("select accepted during warm reset");

  a_cmd_blocked: assert property (@(posedge pclk) disable iff (!presetn)
    !restart_n |=> !cmd_enable)
    else $error("commands enabled while restart low");

  a_warm_config: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == ST_WARM |=> bus_config == $past(nv_bus_config_reg))
    else $error("bus configuration not loaded on reset");

  a_hold_exit: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == ST_HW_HOLD && restart_n |=> state_reg == ST_STANDBY)
    else $error("hold not left when restart high");

  a_wake_standby: assert property (@(posedge pclk) disable iff (!presetn)
    s_wake_ready |=> state_reg == ST_STANDBY)
    else $error("wake did not end in standby");

  a_no_ext_default: assert property (@(posedge pclk) disable iff (!presetn)
    s_cold_done |=> state_reg != ST_EXTEND && por_done_reg)
    else $error("all-ones count added extension");

endmodule

// >>> tb/flash_host_model.sv
// Purpose: Host controller model driving warm restart and chip select
// Assumes: Calls come from the bench at clock rate
// Notes:   Select is held high while restart is low
`timescale 1ns/1ps
module flash_host_model (
  // Clock
  input  wire logic pclk,
  // Flash control pins
  output logic      restart_n,
  output logic      select_n
);
  int high_cyc = 0;

  initial begin
    restart_n = 1'b1;
    select_n  = 1'b1;
  end

  always @(posedge pclk) begin
    high_cyc <= restart_n ? high_cyc + 1 : 0;
  end

  // ----
  // Access tasks
  // ----
  task automatic drive_restart(input logic lvl);
    @(posedge pclk);
    select_n  <= 1'b1;
    restart_n <= lvl;
  endtask

  // Select waits out the restart release gap; a new edge per call keeps a high gap
  task automatic set_select(input logic lvl);
    while (!lvl && high_cyc < 2) @(posedge pclk);
    @(posedge pclk);
    select_n <= lvl;
  endtask
endmodule

// >>> tb/flash_reset_sequencer_tb.sv
// Purpose: Self-checking bench for the flash reset sequencer
// Assumes: Shortened counts through the design parameters
// Notes:   Registers reached through an APB master task
`timescale 1ns/1ps
module flash_reset_sequencer_tb;
  import flash_reset_pkg::*;
  localparam int unsigned SETTLE = 20;
  localparam int unsigned WARM   = 10;
  localparam int unsigned WAKE   = 10;
  localparam int unsigned TICK   = 5;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        restart_n, select_n, rso, rsoe, data_oe, select_accept, cmd_enable;
  logic [15:0] bus_config;
  status_t     st;
  int          fails, n_checks, t0, n;
  int          cyc = 0;

  initial pclk = 1'b0;
  always #50 pclk = ~pclk;

  flash_reset_sequencer #(.SETTLE_CYC(SETTLE), .WARM_CYC(WARM), .TICK_CYC(TICK), .WAKE_CYC(WAKE))
    flash_reset_sequencer_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .restart_n(restart_n), .select_n(select_n), .system_restart_out_n_o(rso),
    .system_restart_out_n_oe(rsoe), .data_oe(data_oe), .select_accept(select_accept),
    .cmd_enable(cmd_enable), .bus_config(bus_config));

  flash_host_model flash_host_model_inst (.pclk(pclk), .restart_n(restart_n), .select_n(select_n));

  // ----
  // Shared tasks
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic read_status();
    apb(1'b0, ADDR_STATUS, 32'h0);
    st = status_t'(rd[7:0]);
  endtask

  // Waits for Standby and returns cycles since t0
  task automatic wait_accept();
    while (select_accept !== 1'b1 && cyc - t0 < 400) @(posedge pclk);
    n = cyc - t0;
  endtask

  always @(posedge pclk) cyc <= cyc + 1;

  // ----
  // Main sequence
  // ----
  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    fails = 0;
    n_checks = 0;
    fork
      begin
        repeat (20000) @(posedge pclk);
        fails++;
        print_verdict();
      end
    join_none
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t0 = cyc;
    flash_host_model_inst.set_select(1'b0);
    repeat (2) @(posedge pclk);
    chk(select_accept, 1'b0);
    chk(data_oe, 1'b0);
    chk({rsoe, rso}, 2'b10);
    flash_host_model_inst.set_select(1'b1);
    while (rsoe !== 1'b0 && cyc - t0 < 200) @(posedge pclk);
    n = cyc - t0;
    chk(n >= SETTLE && n <= SETTLE + 3, 1'b1);
    repeat (2) @(posedge pclk);
    chk(cmd_enable, 1'b1);
    apb(1'b0, ADDR_EXTENSION, 32'h0);
    chk(rd, 32'h0000ffff);
    apb(1'b1, ADDR_EXTENSION, 32'h00000002);
    apb(1'b1, ADDR_EXTENSION, 32'h00000005);
    apb(1'b0, ADDR_EXTENSION, 32'h0);
    chk(rd, 32'h00000002);
    read_status();
    chk({st.ext_programmed, st.ext_fail}, 2'b11);
    apb(1'b0, 8'h10, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    apb(1'b1, ADDR_BUS_CONFIG, 32'h000000a5);
    flash_host_model_inst.set_select(1'b0);
    repeat (2) @(posedge pclk);
    chk(data_oe, 1'b1);
    flash_host_model_inst.set_select(1'b1);
    // Long restart: must wait in hold after the warm algorithm ends
    flash_host_model_inst.drive_restart(1'b0);
    repeat (2) @(posedge pclk);
    chk({data_oe, select_accept, cmd_enable}, 3'b000);
    repeat (WARM + 4) @(posedge pclk);
    read_status();
    chk(st.state, ST_HW_HOLD);
    flash_host_model_inst.drive_restart(1'b1);
    t0 = cyc;
    wait_accept();
    chk(n <= 4, 1'b1);
    chk(bus_config, 16'h00a5);
    apb(1'b1, ADDR_CONTROL, 32'h00000006);
    read_status();
    chk({st.algo_busy, st.overlay}, 2'b11);
    // Minimum pulse: select stays ignored for the whole warm reset
    t0 = cyc;
    flash_host_model_inst.drive_restart(1'b0);
    @(posedge pclk);
    flash_host_model_inst.drive_restart(1'b1);
    wait_accept();
    chk(n >= WARM && n <= WARM + 5, 1'b1);
    read_status();
    chk({st.algo_busy, st.overlay, st.ext_fail}, 3'b000);
    apb(1'b1, ADDR_CONTROL, 32'h00000002);
    read_status();
    chk(st.algo_busy, 1'b1);
    apb(1'b1, ADDR_CONTROL, 32'h00000001);
    read_status();
    chk(st.state, ST_SLEEP);
    t0 = cyc;
    flash_host_model_inst.drive_restart(1'b0);
    @(posedge pclk);
    flash_host_model_inst.drive_restart(1'b1);
    wait_accept();
    chk(select_accept, 1'b1);
    chk(n <= 2 * WAKE, 1'b1);
    // Supply cycle with restart held low: the programmed count now extends
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t0 = cyc;
    flash_host_model_inst.drive_restart(1'b0);
    while (rsoe !== 1'b0 && cyc - t0 < 200) @(posedge pclk);
    n = cyc - t0;
    chk(n >= SETTLE + 3 * TICK && n <= SETTLE + 3 * TICK + 3, 1'b1);
    read_status();
    chk(st.state, ST_HW_HOLD);
    flash_host_model_inst.drive_restart(1'b1);
    wait_accept();
    chk(select_accept, 1'b1);
    chk(bus_config, 16'h00a5);
    apb(1'b1, ADDR_EXTENSION, 32'h00000007);
    apb(1'b0, ADDR_EXTENSION, 32'h0);
    chk(rd, 32'h00000002);
    read_status();
    chk({st.ext_programmed, st.ext_fail}, 2'b11);
    print_verdict();
  end
endmodule
